// >>> include/mpdr_consts.svh
// Constants of the module presence-detect store: offsets, values, map
`ifndef MPDR_CONSTS_SVH
`define MPDR_CONSTS_SVH

// ==========================================================
// Fixed store contents: byte offset and value pairs
`define MPDR_OFS_PROGRAMMED 8'h00
`define MPDR_VAL_PROGRAMMED 8'h80
`define MPDR_OFS_TOTAL 8'h01
`define MPDR_VAL_TOTAL 8'h08
`define MPDR_OFS_MEMTYPE 8'h02
`define MPDR_VAL_MEMTYPE 8'h04
`define MPDR_OFS_ROWS 8'h03
`define MPDR_VAL_ROWS 8'h0c
`define MPDR_OFS_COLS 8'h04
`define MPDR_VAL_COLS 8'h09
`define MPDR_OFS_RANKS 8'h05
`define MPDR_VAL_RANKS 8'h01
`define MPDR_OFS_WIDTH 8'h06
`define MPDR_VAL_WIDTH 8'h40
`define MPDR_OFS_IFTYPE 8'h08
`define MPDR_VAL_IFTYPE 8'h01
`define MPDR_OFS_CYC_HI 8'h09
`define MPDR_VAL_CYC_HI 8'ha0
`define MPDR_OFS_ACC_HI 8'h0a
`define MPDR_VAL_ACC_HI 8'h85
`define MPDR_OFS_REFRESH 8'h0c
`define MPDR_VAL_REFRESH 8'h80
`define MPDR_OFS_PRIMWIDTH 8'h0d
`define MPDR_VAL_PRIMWIDTH 8'h08
`define MPDR_OFS_CHKWIDTH 8'h0e
`define MPDR_VAL_CHKWIDTH 8'h00
`define MPDR_OFS_COLDELAY 8'h0f
`define MPDR_VAL_COLDELAY 8'h01
`define MPDR_OFS_BURSTS 8'h10
`define MPDR_VAL_BURSTS 8'h8f
`define MPDR_OFS_DEVBANKS 8'h11
`define MPDR_VAL_DEVBANKS 8'h04
`define MPDR_OFS_LATENCY 8'h12
`define MPDR_VAL_LATENCY 8'h06
`define MPDR_OFS_CSLAT 8'h13
`define MPDR_VAL_CSLAT 8'h01
`define MPDR_OFS_WRLAT 8'h14
`define MPDR_VAL_WRLAT 8'h01
`define MPDR_OFS_DEVATTR 8'h16
`define MPDR_VAL_DEVATTR 8'h0e
`define MPDR_OFS_CYC_MID 8'h17
`define MPDR_VAL_CYC_MID 8'hf0
`define MPDR_OFS_ACC_MID 8'h18
`define MPDR_VAL_ACC_MID 8'h90
`define MPDR_OFS_CYC_LO 8'h19
`define MPDR_OFS_ACC_LO 8'h1a
`define MPDR_VAL_UNSUPPORTED 8'h00
`define MPDR_OFS_PRECHARGE 8'h1b
`define MPDR_VAL_PRECHARGE 8'h1e
`define MPDR_OFS_BANK_ACT 8'h1c
`define MPDR_VAL_BANK_ACT 8'h14
`define MPDR_OFS_ROW_COL 8'h1d
`define MPDR_VAL_ROW_COL 8'h1e
`define MPDR_OFS_ACTIVE 8'h1e
`define MPDR_VAL_ACTIVE 8'h3c
`define MPDR_OFS_DENSITY 8'h1f
`define MPDR_VAL_DENSITY 8'h10
`define MPDR_OFS_REVISION 8'h3e
`define MPDR_VAL_REVISION 8'h01
`define MPDR_OFS_CHECKSUM 8'h3f
`define MPDR_OFS_FREQ 8'h7e
`define MPDR_VAL_FREQ 8'h66
`define MPDR_OFS_FREQ_DETAIL 8'h7f
`define MPDR_VAL_FREQ_DETAIL 8'hcf
`define MPDR_VAL_UNUSED 8'h00

// ==========================================================
// Serial bus device code (upper four address bits)
`define MPDR_DEV_CODE 4'ha

// ==========================================================
// Register map on the AXI4-Lite slave
`define MPDR_REG_CTRL 12'h000
`define MPDR_REG_STATUS 12'h004
`define MPDR_REG_BLOCKED 12'h008
`define MPDR_WIN_BASE 12'h400
`define MPDR_CTRL_RESET 32'h0000_0003
`define MPDR_CTRL_BUS_EN 0
`define MPDR_CTRL_UPPER_WR 1
`define MPDR_RESP_OKAY 2'b00
`define MPDR_RESP_SLVERR 2'b10

`endif

// >>> include/mpdr_pkg.sv
// Types shared by the presence-detect store design
package mpdr_pkg;

  // ==========================================================
  // Serial slave states
  typedef enum logic [3:0] {
    MPDR_IDLE = 4'b0000,
    MPDR_DEVADDR = 4'b0001,
    MPDR_ACK_ADDR = 4'b0010,
    MPDR_WORDADDR = 4'b0011,
    MPDR_ACK_WORD = 4'b0100,
    MPDR_WRDATA = 4'b0101,
    MPDR_ACK_WR = 4'b0110,
    MPDR_RDDATA = 4'b0111,
    MPDR_RDACK = 4'b1000
  } mpdr_state_t;

  // ==========================================================
  // Status word seen by software
  typedef struct packed {
    logic [14:0] zero;
    logic busy;
    logic [3:0] state;
    logic [3:0] selectPins;
    logic [7:0] offset;
  } mpdr_status_t;

endpackage : mpdr_pkg

// >>> logic/mpdr_presence_detect_store.sv
// Presence-detect byte store: two-wire serial slave plus AXI4-Lite status
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`include "mpdr_consts.svh"
module mpdr_presence_detect_store
  import mpdr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  // Serial bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic [2:0] busSelectPins,
  // AXI4-Lite slave
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ==========================================================
  // Fixed lower half of the store
  function automatic logic [7:0] fixedRaw(input logic [7:0] ofs);
    logic [7:0] val;
    val = `MPDR_VAL_UNUSED; // Unused storage reads zero
    unique case (ofs)
      `MPDR_OFS_PROGRAMMED: val = `MPDR_VAL_PROGRAMMED;
      `MPDR_OFS_TOTAL: val = `MPDR_VAL_TOTAL;
      `MPDR_OFS_MEMTYPE: val = `MPDR_VAL_MEMTYPE;
      `MPDR_OFS_ROWS: val = `MPDR_VAL_ROWS;
      `MPDR_OFS_COLS: val = `MPDR_VAL_COLS;
      `MPDR_OFS_RANKS: val = `MPDR_VAL_RANKS;
      `MPDR_OFS_WIDTH: val = `MPDR_VAL_WIDTH;
      `MPDR_OFS_IFTYPE: val = `MPDR_VAL_IFTYPE;
      `MPDR_OFS_CYC_HI: val = `MPDR_VAL_CYC_HI;
      `MPDR_OFS_ACC_HI: val = `MPDR_VAL_ACC_HI;
      `MPDR_OFS_REFRESH: val = `MPDR_VAL_REFRESH;
      `MPDR_OFS_PRIMWIDTH: val = `MPDR_VAL_PRIMWIDTH;
      `MPDR_OFS_CHKWIDTH: val = `MPDR_VAL_CHKWIDTH;
      `MPDR_OFS_COLDELAY: val = `MPDR_VAL_COLDELAY;
      `MPDR_OFS_BURSTS: val = `MPDR_VAL_BURSTS;
      `MPDR_OFS_DEVBANKS: val = `MPDR_VAL_DEVBANKS;
      `MPDR_OFS_LATENCY: val = `MPDR_VAL_LATENCY;
      `MPDR_OFS_CSLAT: val = `MPDR_VAL_CSLAT;
      `MPDR_OFS_WRLAT: val = `MPDR_VAL_WRLAT;
      `MPDR_OFS_DEVATTR: val = `MPDR_VAL_DEVATTR;
      `MPDR_OFS_CYC_MID: val = `MPDR_VAL_CYC_MID;
      `MPDR_OFS_ACC_MID: val = `MPDR_VAL_ACC_MID;
      `MPDR_OFS_CYC_LO: val = `MPDR_VAL_UNSUPPORTED;
      `MPDR_OFS_ACC_LO: val = `MPDR_VAL_UNSUPPORTED;
      `MPDR_OFS_PRECHARGE: val = `MPDR_VAL_PRECHARGE;
      `MPDR_OFS_BANK_ACT: val = `MPDR_VAL_BANK_ACT;
      `MPDR_OFS_ROW_COL: val = `MPDR_VAL_ROW_COL;
      `MPDR_OFS_ACTIVE: val = `MPDR_VAL_ACTIVE;
      `MPDR_OFS_DENSITY: val = `MPDR_VAL_DENSITY;
      `MPDR_OFS_REVISION: val = `MPDR_VAL_REVISION;
      `MPDR_OFS_FREQ: val = `MPDR_VAL_FREQ;
      `MPDR_OFS_FREQ_DETAIL: val = `MPDR_VAL_FREQ_DETAIL;
      default: val = `MPDR_VAL_UNUSED;
    endcase
    return val;
  endfunction : fixedRaw

  // Low eight bits of the sum of bytes 0 to 62
  function automatic logic [7:0] checksumCalc();
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < 63; i++) begin
      acc = acc + fixedRaw(8'(i));
    end
    return acc;
  endfunction : checksumCalc

  localparam logic [7:0] CHECKSUM = checksumCalc();
  // Upper half of the store, written over the serial bus
  logic [7:0] upperMem [0:127];
  // Byte seen at an offset, used by serial reads and AXI window
  function automatic logic [7:0] storeByte(input logic [7:0] ofs,
                                          input logic [7:0] upper);
    logic [7:0] val;
    if (ofs == `MPDR_OFS_CHECKSUM) begin
      val = CHECKSUM;
    end else if (ofs[7]) begin
      val = upper;
    end else begin
      val = fixedRaw(ofs);
    end
    return val;
  endfunction : storeByte
  // ==========================================================
  // Pin synchronisers
  logic [1:0] sclSync; // Two-stage sampler of the serial clock
  logic [1:0] sdaSync; // Two-stage sampler of the serial data
  logic [2:0] selMeta; // First stage of select pins
  logic [2:0] selPins; // Settled select pins
  logic sclPrev; // Previous settled serial clock
  logic sdaPrev; // Previous settled serial data
  // Both wires and the select pins pass two flops first
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclSync <= 2'b11;
      sdaSync <= 2'b11;
      selMeta <= 3'h0;
      selPins <= 3'h0;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      selMeta <= busSelectPins;
      selPins <= selMeta;
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end
  logic scl; // Settled serial clock
  logic sda; // Settled serial data
  logic sclRise; // Serial clock rising edge
  logic sclFall; // Serial clock falling edge
  logic startCond; // Data falls while clock high
  logic stopCond; // Data rises while clock high
  assign scl = sclSync[1];
  assign sda = sdaSync[1];
  assign sclRise = scl && !sclPrev;
  assign sclFall = !scl && sclPrev;
  assign startCond = scl && sclPrev && sdaPrev && !sda;
  assign stopCond = scl && sclPrev && !sdaPrev && sda;

  // ==========================================================
  // Control register bits
  logic [31:0] ctrl; // Software control word
  logic busEnable; // Answer on the serial bus
  logic upperWrEnable; // Allow writes to bytes 128..255
  assign busEnable = ctrl[`MPDR_CTRL_BUS_EN];
  assign upperWrEnable = ctrl[`MPDR_CTRL_UPPER_WR];
  // ==========================================================
  // Serial slave state
  mpdr_state_t state; // Protocol position
  logic [3:0] bitCnt; // Bits moved in current byte
  logic [7:0] shiftIn; // Received byte
  logic [7:0] shiftOut; // Byte being sent
  logic [7:0] offset; // Current byte offset
  logic readMode; // Direction bit of the address byte
  logic hostAck; // Host acknowledge after a read byte
  logic [15:0] blockedCount; // Writes refused at low offsets, or at any offset with upper writes off
  logic [7:0] upperByte; // Upper-half byte at current offset
  logic addrMatch; // Address byte names this device
  assign upperByte = upperMem[offset[6:0]];
  assign addrMatch = shiftIn[7:1] == {`MPDR_DEV_CODE, selPins};
  // Receive side: sample data on clock rise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shiftIn <= 8'h00;
      hostAck <= 1'b0;
    end else if (sclRise) begin
      shiftIn <= {shiftIn[6:0], sda};
      if (state == MPDR_RDACK) begin
        hostAck <= !sda;
      end
    end
  end
  // Protocol sequencing, advanced on clock fall
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= MPDR_IDLE;
      bitCnt <= 4'h0;
      readMode <= 1'b0;
      offset <= 8'h00;
      shiftOut <= 8'h00;
      sdaOeN <= 1'b1;
      blockedCount <= 16'h0000;
    end else if (!busEnable || stopCond) begin // Bus off or stop: idle
      state <= MPDR_IDLE;
      sdaOeN <= 1'b1;
    end else if (startCond) begin // Start or repeated start
      state <= MPDR_DEVADDR;
      bitCnt <= 4'h0;
      sdaOeN <= 1'b1;
    end else if (sclRise) begin // Count bits in byte-moving states
      if (state == MPDR_DEVADDR || state == MPDR_WORDADDR ||
          state == MPDR_WRDATA || state == MPDR_RDDATA) begin
        bitCnt <= bitCnt + 4'h1;
      end
    end else if (sclFall) begin
      unique case (state)
        MPDR_DEVADDR: begin
          if (bitCnt == 4'h8) begin
            if (addrMatch) begin
              state <= MPDR_ACK_ADDR;
              readMode <= shiftIn[0];
              sdaOeN <= 1'b0; // Pull data low to acknowledge address
            end else begin
              state <= MPDR_IDLE;
            end
          end
        end
        MPDR_ACK_ADDR: begin
          bitCnt <= 4'h0;
          if (readMode) begin
            shiftOut <= storeByte(offset, upperByte);
            sdaOeN <= storeByte(offset, upperByte) >> 7 == 8'h1;
            state <= MPDR_RDDATA; // Read goes on from stored offset
          end else begin
            sdaOeN <= 1'b1;
            state <= MPDR_WORDADDR;
          end
        end
        MPDR_WORDADDR: begin
          if (bitCnt == 4'h8) begin
            offset <= shiftIn;
            sdaOeN <= 1'b0;
            state <= MPDR_ACK_WORD;
          end
        end
        MPDR_ACK_WORD, MPDR_ACK_WR: begin
          sdaOeN <= 1'b1;
          bitCnt <= 4'h0;
          state <= MPDR_WRDATA;
        end
        MPDR_WRDATA: begin
          if (bitCnt == 4'h8) begin
            if (!offset[7] || !upperWrEnable) begin // Refused: count it
              blockedCount <= blockedCount + 16'h0001;
            end
            offset <= offset + 8'h01;
            sdaOeN <= 1'b0;
            state <= MPDR_ACK_WR;
          end
        end
        MPDR_RDDATA: begin
          if (bitCnt == 4'h8) begin
            sdaOeN <= 1'b1; // Release for the host acknowledge
            offset <= offset + 8'h01;
            state <= MPDR_RDACK;
          end else begin
            sdaOeN <= shiftOut[3'(4'h7 - bitCnt)]; // Low for zero
          end
        end
        MPDR_RDACK: begin
          bitCnt <= 4'h0;
          if (hostAck) begin // Host wants another byte
            shiftOut <= storeByte(offset, upperByte);
            sdaOeN <= storeByte(offset, upperByte) >> 7 == 8'h1;
            state <= MPDR_RDDATA;
          end else begin
            sdaOeN <= 1'b1;
            state <= MPDR_IDLE;
          end
        end
        default: begin // Idle or unused code: release
          sdaOeN <= 1'b1;
          state <= MPDR_IDLE;
        end
      endcase
    end
  end
  // Data wire is only ever pulled low
  assign sdaOut = 1'b0;
  // Upper-half storage, written at the end of a data byte
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 128; i++) begin
        upperMem[i] <= `MPDR_VAL_UNUSED;
      end
    end else if (busEnable && sclFall && !startCond && !stopCond &&
                 state == MPDR_WRDATA && bitCnt == 4'h8 &&
                 offset[7] && upperWrEnable) begin
      upperMem[offset[6:0]] <= shiftIn;
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  logic awHeld; // Write address taken
  logic wHeld; // Write data taken
  logic [11:0] awAddrReg; // Held write address
  logic [31:0] wDataReg; // Held write data
  logic [3:0] wStrbReg; // Held byte enables
  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  // Address and data taken in either order
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrReg <= 12'h000;
      wDataReg <= 32'h0000_0000;
      wStrbReg <= 4'h0;
    end else if (awHeld && wHeld) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awAddrReg <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wDataReg <= wdata;
        wStrbReg <= wstrb;
      end
    end
  end
  // Control register update and write response
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl <= `MPDR_CTRL_RESET;
      bvalid <= 1'b0;
      bresp <= `MPDR_RESP_OKAY;
    end else if (awHeld && wHeld) begin
      bvalid <= 1'b1;
      if (awAddrReg[11:2] == 10'(`MPDR_REG_CTRL >> 2)) begin
        bresp <= `MPDR_RESP_OKAY;
        if (wStrbReg[0]) begin
          ctrl <= {30'h0, wDataReg[1:0]};
        end
      end else begin
        bresp <= `MPDR_RESP_SLVERR;
      end
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end
  // ==========================================================
  // AXI4-Lite read channel
  mpdr_status_t status; // Live status word
  logic [7:0] winOffset; // Store offset addressed by the window
  logic [7:0] winUpper; // Upper-half byte for the window
  assign status = '{zero: 15'h0, busy: state != MPDR_IDLE,
                    state: state, selectPins: {1'b0, selPins},
                    offset: offset};
  assign winOffset = araddr[9:2];
  assign winUpper = upperMem[winOffset[6:0]];
  assign arready = !rvalid;
  // One read at a time; answer the cycle after the address
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `MPDR_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `MPDR_RESP_OKAY;
      if (araddr[11:10] == 2'(`MPDR_WIN_BASE >> 10)) begin
        rdata <= {24'h0, storeByte(winOffset, winUpper)};
      end else if (araddr[11:2] == 10'(`MPDR_REG_CTRL >> 2)) begin
        rdata <= ctrl;
      end else if (araddr[11:2] == 10'(`MPDR_REG_STATUS >> 2)) begin
        rdata <= status;
      end else if (araddr[11:2] == 10'(`MPDR_REG_BLOCKED >> 2)) begin
        rdata <= {16'h0, blockedCount};
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= `MPDR_RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : mpdr_presence_detect_store

// >>> verif/mpdr_store_sva.sv
// Checker on the ports of the presence-detect store
// ====================
// Port relations
module mpdr_store_sva
  import mpdr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOeN,
  input wire logic [2:0] busSelectPins,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_write_answer: assert property (
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer missing");
  chk_read_answer: assert property (
    arvalid && arready |-> ##[1:2] rvalid)
    else $error("read answer missing");
  chk_bresp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  chk_rdata_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped early");
  chk_one_read: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  chk_first_byte: assert property (
    arvalid && arready && araddr == 12'h400
    |-> ##[1:2] rvalid && rdata == 32'h0000_0080)
    else $error("first store byte wrong");
  chk_unmapped_err: assert property (
    arvalid && arready && araddr == 12'h00c
    |-> ##[1:2] rvalid && rresp == 2'b10)
    else $error("unmapped read not refused");
  chk_open_drain: assert property (sdaOut == 1'b0)
    else $error("data line driven high");
  chk_drive_low_clk: assert property (
    $changed(sdaOeN) |-> !sclIn)
    else $error("data drive changed with clock high");

  // Main scenarios
  cover property (bvalid && bready && bresp == 2'b10);
  cover property (rvalid && rready && rresp == 2'b10);
  cover property ($fell(sdaOeN));
endmodule : mpdr_store_sva

bind mpdr_presence_detect_store mpdr_store_sva u_mpdr_store_sva (
  .clock(clock), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOeN(sdaOeN), .busSelectPins(busSelectPins),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
  .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready));

// >>> verif/mpdr_host_model.sv
// Two-wire host that frames starts, stops and bytes
module mpdr_host_model (
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaWire
);
  timeunit 1ns;
  timeprecision 100ps;

  // ====================
  // Idle bus: clock stands high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  // Start or repeated start: data falls while clock is high
  task automatic frameStart();
    sdaDrv = 1'b1;
    #24 scl = 1'b1;
    #12 sdaDrv = 1'b0;
    #12 scl = 1'b0;
  endtask : frameStart

  // Stop: data rises while clock is high, clock then stands still
  task automatic frameStop();
    #12 sdaDrv = 1'b0;
    #16 scl = 1'b1;
    #12 sdaDrv = 1'b1;
    #12;
  endtask : frameStop

  // One bit: data set in the low half, sampled in the high half
  task automatic bitXfer(input logic b, output logic seen);
    #12 sdaDrv = b;
    #12 scl = 1'b1;
    #12 seen = sdaWire;
    #12 scl = 1'b0;
  endtask : bitXfer

  // Byte out, most significant bit first, then the answer bit
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitXfer(b[i], s);
    end
    bitXfer(1'b1, s);
    ack = !s;
  endtask : sendByte

  // Byte in; the last byte of a read is refused
  task automatic getByte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitXfer(1'b1, s);
      b[i] = s;
    end
    bitXfer(last, s);
  endtask : getByte
endmodule : mpdr_host_model

// >>> verif/test_mpdr_presence_detect_store.sv
// Self-checking bench for the presence-detect store
`include "mpdr_consts.svh"

module test_mpdr_presence_detect_store;
  timeunit 1ns;
  timeprecision 100ps;

  // ====================
  // Signals
  logic clock, rst, scl, hostSda, sdaOut, sdaOeN, sdaWire;
  logic [2:0] pins;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] b;
  int failCount = 0;
  int totalChecks = 0;
  int cycles = 0;

  // Wire level: host and device both only pull low
  assign sdaWire = hostSda & (sdaOeN | sdaOut);

  mpdr_presence_detect_store u_mpdr_presence_detect_store (
    .clock(clock), .rst(rst), .sclIn(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .busSelectPins(pins),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  mpdr_host_model u_mpdr_host_model (
    .scl(scl), .sdaDrv(hostSda), .sdaWire(sdaWire));

  // Clock generator
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Watchdog on a hung run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      failCount++;
      printVerdict();
    end
  end

  task automatic printVerdict();
    if (failCount == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : printVerdict

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Expected store contents
  function automatic logic [7:0] expByte(input int n);
    case (n)
      0: return 8'h80;
      1, 13: return 8'h08;
      2, 17: return 8'h04;
      3: return 8'h0c;
      4: return 8'h09;
      5, 8, 15, 19, 20, 62: return 8'h01;
      6: return 8'h40;
      9: return 8'ha0;
      10: return 8'h85;
      12: return 8'h80;
      16: return 8'h8f;
      18: return 8'h06;
      22: return 8'h0e;
      23: return 8'hf0;
      24: return 8'h90;
      27, 29: return 8'h1e;
      28: return 8'h14;
      30: return 8'h3c;
      31: return 8'h10;
      126: return 8'h66;
      127: return 8'hcf;
      default: return 8'h00;
    endcase
  endfunction : expByte

  function automatic logic [7:0] sumLow();
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 63; i++) begin
      s += expByte(i);
    end
    return s;
  endfunction : sumLow

  // AXI4-Lite write: both channels offered, held until taken
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b1;
    @(posedge clock);
    r = bresp;
    bready <= 1'b0;
  endtask : axiWrite

  // AXI4-Lite read, data taken at the answering edge
  task automatic axiRead(input logic [11:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b1;
    @(posedge clock);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axiRead

  // Start plus address byte, answer compared
  task automatic addrPhase(input logic rw, input logic [2:0] p,
                           input logic want);
    logic a;
    u_mpdr_host_model.frameStart();
    u_mpdr_host_model.sendByte({`MPDR_DEV_CODE, p, rw}, a);
    check("address ack", a, want);
  endtask : addrPhase

  task automatic serialWrite(input logic [7:0] o, input logic [7:0] v);
    logic a;
    addrPhase(1'b0, pins, 1'b1);
    u_mpdr_host_model.sendByte(o, a);
    u_mpdr_host_model.sendByte(v, a);
    check("data ack", a, 1'b1);
    u_mpdr_host_model.frameStop();
  endtask : serialWrite

  // Offset set, then repeated start for reading
  task automatic serialSeek(input logic [7:0] o);
    logic a;
    addrPhase(1'b0, pins, 1'b1);
    u_mpdr_host_model.sendByte(o, a);
    addrPhase(1'b1, pins, 1'b1);
  endtask : serialSeek

  task automatic testRegisters();
    axiRead(`MPDR_REG_CTRL);
    check("ctrl reset", d, `MPDR_CTRL_RESET);
    axiRead(`MPDR_REG_STATUS);
    check("select pins", d[10:8], pins);
    axiRead(`MPDR_WIN_BASE);
    check("window byte 0", d, 32'h80);
    axiRead(12'h4fc);
    check("window checksum", d, sumLow());
    axiRead(12'h00c);
    check("unmapped read", r, `MPDR_RESP_SLVERR);
    axiWrite(12'h00c, 32'h1);
    check("unmapped write", r, `MPDR_RESP_SLVERR);
  endtask : testRegisters

  // Whole lower half read in one sequential burst
  task automatic testReadAll();
    serialSeek(8'h00);
    for (int i = 0; i < 128; i++) begin
      u_mpdr_host_model.getByte(i == 127, b);
      if (i < 12) check("store", b, expByte(i));
      else if (i < 25) check("store", b, expByte(i));
      else if (i < 63) check("store", b, expByte(i));
      else if (i == 63) check("checksum", b, sumLow());
      else check("store", b, expByte(i));
    end
    u_mpdr_host_model.frameStop();
  endtask : testReadAll

  task automatic testWrites();
    serialWrite(8'h05, 8'h55);
    axiRead(12'h414);
    check("lower byte kept", d, 32'h01);
    axiRead(`MPDR_REG_BLOCKED);
    check("refused count", d, 32'h1);
    serialWrite(8'hc8, 8'ha5);
    serialSeek(8'hc8);
    u_mpdr_host_model.getByte(1'b0, b);
    check("upper byte", b, 8'ha5);
    u_mpdr_host_model.getByte(1'b1, b);
    check("next byte", b, 8'h00);
    u_mpdr_host_model.frameStop();
  endtask : testWrites

  // Offset wraps, and a bare read continues where the last stopped
  task automatic testSequential();
    serialSeek(8'hff);
    u_mpdr_host_model.getByte(1'b0, b);
    check("last byte", b, 8'h00);
    u_mpdr_host_model.getByte(1'b1, b);
    check("wrapped byte", b, 8'h80);
    u_mpdr_host_model.frameStop();
    addrPhase(1'b1, pins, 1'b1);
    u_mpdr_host_model.getByte(1'b1, b);
    check("current offset", b, 8'h08);
    u_mpdr_host_model.frameStop();
  endtask : testSequential

  task automatic testRefusals();
    addrPhase(1'b0, ~pins, 1'b0);
    u_mpdr_host_model.frameStop();
    axiWrite(`MPDR_REG_CTRL, 32'h2);
    addrPhase(1'b0, pins, 1'b0);
    u_mpdr_host_model.frameStop();
    axiWrite(`MPDR_REG_CTRL, 32'h1);
    serialWrite(8'hd2, 8'h77);
    axiRead(12'h748);
    check("upper write off", d, 32'h0);
    axiRead(`MPDR_REG_BLOCKED);
    check("refused count", d, 32'h2);
    axiWrite(`MPDR_REG_CTRL, 32'h3);
  endtask : testRefusals

  // Main sequence
  initial begin
    rst = 1'b1;
    pins = 3'b101;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    testRegisters();
    testReadAll();
    testWrites();
    testSequential();
    testRefusals();
    printVerdict();
  end
endmodule : test_mpdr_presence_detect_store
